// *** include/bps_defines.vh ***
// constants for the buck pwm supervisor: register map, fields, timing
// assumes a 10 MHz pclk and 32-bit apb data
`ifndef BPS_DEFINES_VH
`define BPS_DEFINES_VH

// register byte offsets
`define BPS_ADDR_W 12
`define BPS_OFF_PERIOD 12'h000
`define BPS_OFF_STATUS 12'h004
`define BPS_OFF_INT_STAT 12'h008
`define BPS_OFF_INT_MASK 12'h00C
`define BPS_OFF_SS_COUNT 12'h010

// interrupt event bits
`define BPS_EV_W 4
`define BPS_EV_SS_DONE 0
`define BPS_EV_OVP 1
`define BPS_EV_OC 2
`define BPS_EV_SUPPLY 3

// switching period in pclk cycles
`define BPS_CLK_KHZ 10000
`define BPS_FSW_MIN_KHZ 50
`define BPS_FSW_MAX_KHZ 1000
`define BPS_PER_W 8
// clk_khz / fsw_min_khz and clk_khz / fsw_max_khz, sized to the period field
`define BPS_PER_MAX 8'hC8
`define BPS_PER_MIN 8'h0A
`define BPS_PER_RST 8'h21

// timing
`define BPS_CLK_NS 100
`define BPS_DEAD_NS 20
`define BPS_BLANK_NS 300
// dead time and blanking rounded up to whole pclk cycles, counter width
`define BPS_DEAD_CYC 4'h1
`define BPS_BLANK_CYC 4'h3
`define BPS_SS_W 12
`define BPS_SS_CYCLES 12'h800
`define BPS_SS_SHIFT 11
`define BPS_DMAX_NUM 4'h9
`define BPS_DMAX_DEN 4'hA
`define BPS_CNT_W 4

`endif

// *** logic/bps_top.v ***
// buck pwm supervisor: start-up sequencing, pwm, protection, apb registers
// assumes all comparator flags arrive already synchronous to pclk
`include "bps_defines.vh"

// Function
// - soft start begins only with supply ok, enable high, id code valid
// - soft start counts 2048 switching cycles, ramping the duty limit
// - power good held low through soft start, then follows monitor
// - below start threshold: held in power-on reset, both gates off
// - supply below stop threshold returns to power-on reset
// - overvoltage after soft start latches: high gate low, low gate high
// - overvoltage cleared by supply cycle or enable toggle, then soft start
// - overvoltage also cleared by floating id code then valid code
// - duty from comparing loop level against internal ramp each cycle
// - switching frequency selectable from 50 kHz to 1 MHz
// - a gate turns on only after the other is off plus dead time
// - after soft start, outside the 5% window force maximum or zero duty
// - power good asserted when output within 10% after soft start
// - current sampled 300 ns after high turn-on; trip ends pulse
// - over-current declared when sensed drop exceeds limit threshold
module bps_top (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`BPS_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // comparator flags and control pins
    input wire vcc_above_start,
    input wire vcc_below_stop,
    input wire output_enable,
    input wire voltage_id_code_valid,
    input wire voltage_id_code_float,
    input wire window_low,
    input wire window_high,
    input wire ovp_trip,
    input wire pg_in_range,
    input wire current_limit_sense_pin,
    input wire [`BPS_PER_W-1:0] loop_level,
    // gate drives and flags
    output reg high_gate,
    output reg low_gate,
    output reg power_good_flag,
    output reg irq
);

    localparam [4:0] ST_POR = 5'h01;
    localparam [4:0] ST_IDLE = 5'h02;
    localparam [4:0] ST_SS = 5'h04;
    localparam [4:0] ST_RUN = 5'h08;
    localparam [4:0] ST_OVP = 5'h10;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg supply_ok_q;
    reg en_prev_q;
    reg float_seen_q;
    reg [`BPS_SS_W-1:0] ss_cnt_q;
    reg [`BPS_PER_W-1:0] period_q;
    reg [`BPS_PER_W-1:0] phase_q;
    reg oc_cut_q;
    reg [`BPS_CNT_W-1:0] blank_q;
    reg [`BPS_CNT_W-1:0] gap_q;
    reg [`BPS_EV_W-1:0] int_stat_q;
    reg [`BPS_EV_W-1:0] int_mask_q;
    reg hs_d;
    reg ls_d;
    reg want_hs;
    reg want_ls;
    reg pwm_on;
    reg [`BPS_PER_W-1:0] duty;
    reg [31:0] rd_word;
    reg addr_ok;
    reg wr_ok;

    // last ramp count marks the switching cycle boundary
    wire cyc_start = (phase_q == period_q - 8'h01);
    // soft start ceiling grows as period * count / 2048
    wire [18:0] ss_prod = period_q * ss_cnt_q[10:0];
    wire [`BPS_PER_W-1:0] ss_limit = ss_prod[18:11];
    // duty ceiling keeps a low-side interval in every cycle
    wire [11:0] dmax_prod = period_q * `BPS_DMAX_NUM;
    wire [11:0] dmax_full = dmax_prod / `BPS_DMAX_DEN;
    wire [`BPS_PER_W-1:0] max_on = dmax_full[`BPS_PER_W-1:0];
    wire gap_ok = (gap_q >= `BPS_DEAD_CYC);
    wire blank_ok = (blank_q >= `BPS_BLANK_CYC);
    wire en_fall = en_prev_q & ~output_enable;
    // writes land on the pready edge, where the bus commits them
    wire wr_en = psel & penable & pwrite & pready;
    wire wr_req = psel & penable & pwrite & ~pready;
    wire rd_en = psel & penable & ~pwrite & ~pready;
    wire [`BPS_EV_W-1:0] ev_set;
    wire [`BPS_PER_W-1:0] wr_per = pwdata[`BPS_PER_W-1:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ok_q <= 1'b0;
        end else if (vcc_below_stop) begin
            supply_ok_q <= 1'b0;
        end else if (vcc_above_start) begin
            supply_ok_q <= 1'b1;
        end
    end

    // state machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_POR: begin
                if (supply_ok_q) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (output_enable && voltage_id_code_valid) begin
                    state_d = ST_SS;
                end
            end
            ST_SS: begin
                if (!output_enable) begin
                    state_d = ST_IDLE;
                end else if (ss_cnt_q == `BPS_SS_CYCLES) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ovp_trip) begin
                    state_d = ST_OVP;
                end else if (!output_enable) begin
                    state_d = ST_IDLE;
                end
            end
            ST_OVP: begin
                if (en_fall) begin
                    state_d = ST_IDLE;
                end else if (float_seen_q && voltage_id_code_valid &&
                             !voltage_id_code_float && output_enable) begin
                    state_d = ST_SS;
                end
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        if (!supply_ok_q) begin
            state_d = ST_POR;
        end
    end

    // float seen only while latched, so a stale float cannot clear a later trip
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_POR;
            en_prev_q <= 1'b0;
            float_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_prev_q <= output_enable;
            if (state_q != ST_OVP) begin
                float_seen_q <= 1'b0;
            end else if (voltage_id_code_float) begin
                float_seen_q <= 1'b1;
            end
        end
    end

    // switching period from software frequency setting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= {`BPS_PER_W{1'b0}};
        end else if (cyc_start || phase_q >= period_q) begin
            phase_q <= {`BPS_PER_W{1'b0}};
        end else begin
            phase_q <= phase_q + 8'h01;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_cnt_q <= {`BPS_SS_W{1'b0}};
        end else if (state_q != ST_SS) begin
            ss_cnt_q <= {`BPS_SS_W{1'b0}};
        end else if (cyc_start && ss_cnt_q != `BPS_SS_CYCLES) begin
            ss_cnt_q <= ss_cnt_q + 12'h001;
        end
    end

    // blanking after high turn-on, cut until next cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_q <= {`BPS_CNT_W{1'b0}};
            oc_cut_q <= 1'b0;
        end else begin
            if (!high_gate) begin
                blank_q <= {`BPS_CNT_W{1'b0}};
            end else if (!blank_ok) begin
                blank_q <= blank_q + 4'h1;
            end
            if (cyc_start) begin
                oc_cut_q <= 1'b0;
            end else if (high_gate && blank_ok && current_limit_sense_pin) begin
                oc_cut_q <= 1'b1;
            end
        end
    end

    // duty selection and gate wishes
    always @* begin
        duty = loop_level;
        if (duty > max_on) begin
            duty = max_on;
        end
        // limit ramps up during soft start
        if (state_q == ST_SS && duty > ss_limit) begin
            duty = ss_limit;
        end
        pwm_on = (phase_q < duty);
        if (state_q == ST_RUN && window_high) begin
            pwm_on = 1'b0;
        end else if (state_q == ST_RUN && window_low) begin
            pwm_on = (phase_q < max_on);
        end
        want_hs = 1'b0;
        want_ls = 1'b0;
        case (state_q)
            ST_SS, ST_RUN: begin
                // trip turns high off, low on
                // sense is switching noise until blanking has run out
                want_hs = pwm_on & ~oc_cut_q;
                want_ls = ~want_hs;
                if (high_gate && blank_ok && current_limit_sense_pin) begin
                    want_hs = 1'b0;
                    want_ls = 1'b1;
                end
            end
            ST_OVP: begin
                want_ls = 1'b1;
            end
            default: begin
                want_hs = 1'b0;
                want_ls = 1'b0;
            end
        endcase
        // other gate off for dead time first
        hs_d = want_hs & (high_gate | (~low_gate & gap_ok));
        ls_d = want_ls & (low_gate | (~high_gate & gap_ok));
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_gate <= 1'b0;
            low_gate <= 1'b0;
            gap_q <= {`BPS_CNT_W{1'b0}};
            power_good_flag <= 1'b0;
        end else begin
            high_gate <= hs_d;
            low_gate <= ls_d;
            if (high_gate || low_gate) begin
                gap_q <= {`BPS_CNT_W{1'b0}};
            end else if (!gap_ok) begin
                gap_q <= gap_q + 4'h1;
            end
            power_good_flag <= (state_d == ST_RUN) && (state_q == ST_RUN) &&
                               pg_in_range;
        end
    end

    // interrupt events
    // each is a one-cycle pulse on its transition
    assign ev_set[`BPS_EV_SS_DONE] = (state_q == ST_SS) && (state_d == ST_RUN);
    assign ev_set[`BPS_EV_OVP] = (state_q != ST_OVP) && (state_d == ST_OVP);
    assign ev_set[`BPS_EV_OC] = ~oc_cut_q & high_gate & blank_ok & current_limit_sense_pin;
    assign ev_set[`BPS_EV_SUPPLY] = (state_q != ST_POR) && (state_d == ST_POR);

    // address decode; unmapped reads return zero
    always @* begin
        rd_word = 32'h00000000;
        addr_ok = 1'b1;
        wr_ok = 1'b0;
        if (paddr == `BPS_OFF_PERIOD) begin
            rd_word = {24'h000000, period_q};
            wr_ok = 1'b1;
        end else if (paddr == `BPS_OFF_STATUS) begin
            rd_word = {21'h000000, float_seen_q, oc_cut_q, supply_ok_q,
                       power_good_flag, state_q, low_gate, high_gate};
        end else if (paddr == `BPS_OFF_INT_STAT) begin
            rd_word = {28'h0000000, int_stat_q};
            wr_ok = 1'b1;
        end else if (paddr == `BPS_OFF_INT_MASK) begin
            rd_word = {28'h0000000, int_mask_q};
            wr_ok = 1'b1;
        end else if (paddr == `BPS_OFF_SS_COUNT) begin
            rd_word = {20'h00000, ss_cnt_q};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // apb slave, one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_q <= `BPS_PER_RST;
            int_mask_q <= {`BPS_EV_W{1'b0}};
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            // errors decided on the first access edge so they stand with pready
            if (rd_en) begin
                prdata <= rd_word;
                pslverr <= ~addr_ok;
            end
            if (wr_req) begin
                pslverr <= ~wr_ok;
            end
            if (wr_en && paddr == `BPS_OFF_PERIOD) begin
                // clamp to 50 kHz .. 1 MHz
                if (wr_per < `BPS_PER_MIN) begin
                    period_q <= `BPS_PER_MIN;
                end else if (wr_per > `BPS_PER_MAX) begin
                    period_q <= `BPS_PER_MAX;
                end else begin
                    period_q <= wr_per;
                end
            end
            if (wr_en && paddr == `BPS_OFF_INT_MASK) begin
                int_mask_q <= pwdata[`BPS_EV_W-1:0];
            end
        end
    end

    // sticky status: an event in the clear cycle still sets its bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= {`BPS_EV_W{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr_en && paddr == `BPS_OFF_INT_STAT) begin
                int_stat_q <= (int_stat_q & ~pwdata[`BPS_EV_W-1:0]) | ev_set;
            end else begin
                int_stat_q <= int_stat_q | ev_set;
            end
            // irq rises on the same edge as its status bit, falls one edge after a clear
            irq <= |((int_stat_q | ev_set) & int_mask_q);
        end
    end

endmodule

// *** verif/bps_fet_model.sv ***
// external high-side switch and its drain-drop comparator
// assumes oc_cmd from the bench asks for a current above the limit
module bps_fet_model (
    input wire pclk,
    input wire high_gate,
    input wire oc_cmd,
    output logic current_limit_sense_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge pclk) begin
        current_limit_sense_pin <= oc_cmd && high_gate;
    end
endmodule

// *** verif/bps_properties.sv ***
// checker for the buck pwm supervisor, watching top ports only
// assumes one pclk domain with presetn active low
module bps_properties (
    // apb
    input wire pclk, input wire presetn, input wire psel, input wire penable,
    input wire pready, input wire pslverr,
    // flags and gates
    input wire vcc_below_stop, input wire output_enable, input wire ovp_trip,
    input wire pg_in_range, input wire current_limit_sense_pin,
    input wire high_gate, input wire low_gate, input wire power_good_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // trip seen once blanking has run out
    sequence oc_seen;
        $rose(high_gate) ##3 (high_gate && current_limit_sense_pin);
    endsequence
    sequence ovp_seen;
        power_good_flag && ovp_trip ##1 (output_enable && !vcc_below_stop) [*5];
    endsequence
    a_no_overlap: assert property (!(high_gate && low_gate))
        else $error("both gates high");
    a_dead_high: assert property ($rose(high_gate) |-> !$past(low_gate))
        else $error("high gate on without dead cycle");
    a_dead_low: assert property ($rose(low_gate) |-> !$past(high_gate))
        else $error("low gate on without dead cycle");
    a_supply_off: assert property (vcc_below_stop [*4] |-> !high_gate && !low_gate)
        else $error("gates on after supply loss");
    a_pg_cause: assert property ($rose(power_good_flag) |-> $past(pg_in_range))
        else $error("power good rose out of range");
    a_oc_cut: assert property (oc_seen |-> ##[1:2] !high_gate ##[1:2] low_gate)
        else $error("over-current did not end pulse");
    a_ovp_hold: assert property (ovp_seen |-> !high_gate && low_gate && !power_good_flag)
        else $error("overvoltage gates wrong");
    a_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    c_pg: cover property ($rose(power_good_flag));
    c_err: cover property (pslverr);
    c_oc: cover property (oc_seen);
    c_ovp: cover property (ovp_seen);
endmodule

bind bps_top bps_properties u_bps_properties (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .vcc_below_stop, .output_enable, .ovp_trip, .pg_in_range,
    .current_limit_sense_pin, .high_gate, .low_gate, .power_good_flag);

// *** verif/tb.sv ***
// self-checking bench for the buck pwm supervisor
// assumes the checker bind and fet model are compiled before it
`include "bps_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PER = 10;
    localparam int SS = `BPS_SS_CYCLES * PER;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [`BPS_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic vcc_above_start, vcc_below_stop, output_enable, voltage_id_code_valid;
    logic voltage_id_code_float, window_low, window_high, ovp_trip, pg_in_range;
    logic current_limit_sense_pin, oc_cmd, high_gate, low_gate, power_good_flag, irq;
    logic [`BPS_PER_W-1:0] loop_level;
    int fail_count = 0;
    int total_checks = 0;
    int n;

    bps_top u_bps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .vcc_above_start, .vcc_below_stop, .output_enable,
        .voltage_id_code_valid, .voltage_id_code_float, .window_low, .window_high,
        .ovp_trip, .pg_in_range, .current_limit_sense_pin, .loop_level, .high_gate,
        .low_gate, .power_good_flag, .irq);
    bps_fet_model u_bps_fet_model (.pclk, .high_gate, .oc_cmd, .current_limit_sense_pin);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // one idle edge first, so psel never changes twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 20) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask

    task automatic cnt_high(input int k);
        n = 0;
        repeat (k) begin
            @(posedge pclk);
            if (high_gate === 1'b1) n++;
        end
    endtask

    // wait for power good to rise, counting cycles in n; fail after 30000
    task automatic wait_pg;
        n = 0;
        while (power_good_flag !== 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 30000) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic t_regs;
        rdc("status por", `BPS_OFF_STATUS, 32'h7F, 32'h04);
        rdc("period reset", `BPS_OFF_PERIOD, 32'hFF, 32'h21);
        rdc("mask reset", `BPS_OFF_INT_MASK, 32'hF, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, `BPS_OFF_PERIOD, 32'h5);
        rdc("period low", `BPS_OFF_PERIOD, 32'hFF, 32'h0A);
        apb(1'b1, `BPS_OFF_PERIOD, 32'hFA);
        rdc("period high", `BPS_OFF_PERIOD, 32'hFF, 32'hC8);
        apb(1'b1, `BPS_OFF_PERIOD, 32'h0A);
        apb(1'b1, `BPS_OFF_INT_MASK, 32'hF);
    endtask

    task automatic t_start;
        vcc_above_start <= 1'b1;
        output_enable <= 1'b1;
        cyc(5);
        rdc("idle no id", `BPS_OFF_STATUS, 32'h7C, 32'h08);
        voltage_id_code_valid <= 1'b1;
        cyc(3);
        rdc("soft start", `BPS_OFF_STATUS, 32'h7C, 32'h10);
        wait_pg();
        chk("ss length", 32'(n >= SS - 10 && n <= SS + 30), 32'h1);
        rdc("ss done", `BPS_OFF_INT_STAT, 32'hF, 32'h1);
        chk("irq set", 32'(irq), 32'h1);
        apb(1'b1, `BPS_OFF_INT_STAT, 32'h1);
        cyc(2);
        chk("irq clear", 32'(irq), 32'h0);
    endtask

    task automatic t_window;
        loop_level <= 8'h05;
        // let the dead-time pattern settle before counting
        cyc(20);
        cnt_high(100);
        chk("duty mid", 32'(n >= 30 && n <= 60), 32'h1);
        window_high <= 1'b1;
        cyc(3);
        cnt_high(100);
        chk("duty zero", 32'(n), 32'h0);
        window_high <= 1'b0;
        window_low <= 1'b1;
        cyc(3);
        cnt_high(100);
        chk("duty max", 32'(n >= 70 && n <= 90), 32'h1);
        window_low <= 1'b0;
        pg_in_range <= 1'b0;
        cyc(3);
        chk("pg out of range", 32'(power_good_flag), 32'h0);
        pg_in_range <= 1'b1;
        cyc(3);
        chk("pg back in range", 32'(power_good_flag), 32'h1);
    endtask

    task automatic t_oc;
        loop_level <= 8'h08;
        apb(1'b1, `BPS_OFF_INT_MASK, 32'hB);
        oc_cmd <= 1'b1;
        cnt_high(100);
        chk("oc duty", 32'(n >= 20 && n <= 45), 32'h1);
        oc_cmd <= 1'b0;
        rdc("oc event", `BPS_OFF_INT_STAT, 32'h4, 32'h4);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, `BPS_OFF_INT_MASK, 32'hF);
        cyc(2);
        chk("irq unmasked", 32'(irq), 32'h1);
        apb(1'b1, `BPS_OFF_INT_STAT, 32'h4);
        rdc("oc cleared", `BPS_OFF_INT_STAT, 32'h4, 32'h0);
    endtask

    task automatic t_ovp(input logic by_float);
        ovp_trip <= 1'b1;
        cyc(3);
        ovp_trip <= 1'b0;
        cnt_high(50);
        chk("ovp high gate", 32'(n), 32'h0);
        chk("ovp low gate", 32'(low_gate), 32'h1);
        chk("ovp pg", 32'(power_good_flag), 32'h0);
        rdc("ovp state", `BPS_OFF_STATUS, 32'h7C, 32'h40);
        rdc("ovp event", `BPS_OFF_INT_STAT, 32'h2, 32'h2);
        if (by_float) begin
            voltage_id_code_valid <= 1'b0;
            voltage_id_code_float <= 1'b1;
            cyc(3);
            voltage_id_code_float <= 1'b0;
            voltage_id_code_valid <= 1'b1;
        end else begin
            output_enable <= 1'b0;
            cyc(3);
            rdc("ovp to idle", `BPS_OFF_STATUS, 32'h7C, 32'h08);
            output_enable <= 1'b1;
        end
        cyc(3);
        rdc("restart", `BPS_OFF_STATUS, 32'h7C, 32'h10);
    endtask

    task automatic t_supply;
        vcc_below_stop <= 1'b1;
        vcc_above_start <= 1'b0;
        cyc(5);
        chk("por gates", 32'({high_gate, low_gate}), 32'h0);
        rdc("por state", `BPS_OFF_STATUS, 32'h7C, 32'h04);
        rdc("supply event", `BPS_OFF_INT_STAT, 32'h8, 32'h8);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, vcc_above_start, vcc_below_stop, output_enable,
            voltage_id_code_valid, voltage_id_code_float, window_low, window_high,
            ovp_trip, oc_cmd} = '0;
        paddr = '0;
        pwdata = '0;
        loop_level = 8'h00;
        pg_in_range = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_start();
        t_window();
        t_oc();
        t_ovp(1'b0);
        wait_pg();
        t_ovp(1'b1);
        t_supply();
        wrap_up();
    end
endmodule
